// file: pic_defs.svh
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// Register indices as printed; byte address on APB is four times the index.
`define PIC_IDX_PRIO_A 32'hFFFF8348
`define PIC_IDX_PRIO_B 32'hFFFF834A
`define PIC_IDX_PRIO_C 32'hFFFF834C
`define PIC_IDX_PRIO_D 32'hFFFF834E
`define PIC_IDX_PRIO_E 32'hFFFF8350
`define PIC_IDX_PRIO_F 32'hFFFF8352
`define PIC_IDX_PRIO_G 32'hFFFF8354
`define PIC_IDX_PRIO_H 32'hFFFF8356
`define PIC_IDX_CTRL 32'hFFFF8358
`define PIC_IDX_FLAGS 32'hFFFF835A
`define PIC_IDX_STEP 8'h02

// interrupt_control fields
`define PIC_CTRL_NMI_LVL_BIT 15
`define PIC_CTRL_POL_BIT 8

// Reset values
`define PIC_PRIO_RESET 16'h0000
`define PIC_SENSE_RESET 8'h00
`define PIC_FLAGS_RESET 8'h00
`define PIC_EXT_IDLE 8'hFF

// Source counts and arbitration slots, highest default rank first
`define PIC_NUM_EXT 8
`define PIC_NUM_PER 24
`define PIC_NUM_SRC 34
`define PIC_SRC_NMI 6'h00
`define PIC_SRC_BRK 6'h01
`define PIC_SRC_EXT 6'h02
`define PIC_SRC_PER 6'h0A

// Fixed levels
`define PIC_LVL_NMI 5'h10
`define PIC_LVL_BRK 5'h0F
`define PIC_MASK_FIXED 4'hF

// Vector numbers
`define PIC_VEC_NMI 8'h0B
`define PIC_VEC_BRK 8'h0C
`define PIC_VEC_EXT 8'h40
`define PIC_VEC_PER 8'h48
`define PIC_VEC_PER_STEP 8'h04

`endif

// file: pic_pkg.sv
package pic_pkg;

	typedef logic [3:0] pic_level_t;

	// Request presented to the processor core
	typedef struct packed {
		logic valid;
		logic [7:0] vector;
		pic_level_t mask_level;
	} pic_cpu_req_s;

	typedef struct packed {
		logic [1:0] nmi_sync;
		logic nmi_prev;
		logic nmi_pend;
		logic brk_prev;
		logic brk_pend;
		logic [7:0] ext_meta;
		logic [7:0] ext_sync;
		logic [7:0] ext_prev;
		logic [7:0] ext_latch;
		logic [7:0][15:0] prio;
		logic edge_polarity_select;
		logic [7:0] sense_select_bits;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		pic_cpu_req_s req;
		logic [5:0] src;
		logic request_notify_out_n;
	} pic_state_s;

endpackage : pic_pkg

// file: pic_priority_controller.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "pic_defs.svh"

// Notes on behaviour
// R1: Levels 0 to 16; level 0 never forwarded.
// R2: Non-maskable request level 16, ignores mask.
// R3: Non-maskable edge; polarity chosen by control bit.
// R4: Non-maskable acceptance loads mask level 15.
// R5: Control register shows live non-maskable pin level.
// R6: Control reads 0x8000 pin high, else 0x0000; code also returns bits 8 and 7:0.
// R7: Break request level 15, edge, held till accepted.
// R8: Break acceptance loads mask level 15.
// R9: Per-pin sense bit: low level or falling edge.
// R10: Pin priorities 0-15 in first two registers.
// R11: Level mode: request and flag follow pin low.
// R12: Edge mode: falling edge latched until accepted.
// R13: Software cancels latched edge by writing zero.
// R14: Flag register writes only clear, never set.
// R15: Pin acceptance loads mask with pin priority.
// R16: Each peripheral source has distinct vector.
// R17: Peripheral priorities 0-15 in registers three-eight.
// R18: Peripheral acceptance loads mask with its level.
// R19: Notify pin shows an interrupt is pending.
// R20: Reset clears all programmable priorities to 0.
// R21: Equal levels resolved by fixed source ranking.
// R22: Maskable forwarded only above current mask level.
module pic_priority_controller (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nmi_pin,
	input wire logic [7:0] ext_request_pins_n,
	input wire logic break_req,
	input wire logic [23:0] periph_req,
	input wire logic [3:0] cpu_mask_level,
	input wire logic cpu_ack,
	output pic_pkg::pic_cpu_req_s cpu_req,
	output logic request_notify_out_n
);

	// Only the low byte of each index is decoded; the upper bits match for all ten
	localparam logic [7:0] idx_prio_a = 8'(`PIC_IDX_PRIO_A);
	localparam logic [7:0] idx_prio_b = 8'(`PIC_IDX_PRIO_B);
	localparam logic [7:0] idx_prio_c = 8'(`PIC_IDX_PRIO_C);
	localparam logic [7:0] idx_prio_d = 8'(`PIC_IDX_PRIO_D);
	localparam logic [7:0] idx_prio_e = 8'(`PIC_IDX_PRIO_E);
	localparam logic [7:0] idx_prio_f = 8'(`PIC_IDX_PRIO_F);
	localparam logic [7:0] idx_prio_g = 8'(`PIC_IDX_PRIO_G);
	localparam logic [7:0] idx_prio_h = 8'(`PIC_IDX_PRIO_H);
	localparam logic [7:0] idx_ctrl = 8'(`PIC_IDX_CTRL);
	localparam logic [7:0] idx_flags = 8'(`PIC_IDX_FLAGS);

	pic_pkg::pic_state_s s;
	pic_pkg::pic_state_s next_s;

	always_comb begin
		logic setup;
		logic access;
		logic [7:0] idx;
		logic hit_prio;
		logic hit_ctrl;
		logic hit_flags;
		logic [2:0] prio_sel;
		logic [15:0] rd;
		logic [15:0] wmask;
		logic [7:0] flags;
		logic nmi_edge;
		logic brk_edge;
		logic ack;
		logic [33:0] act;
		logic [33:0][4:0] lvl;
		logic [33:0] elig;
		logic found;
		logic [4:0] best_lvl;
		logic [5:0] best_src;
		logic [7:0] best_vec;
		logic ext_clr;
		logic [7:0] ext_fall;
		logic [7:0] ext_set;
		logic nmi_clr;
		logic brk_clr;
		logic hit_any;
		logic wr_en;
		logic flag_wr;
		logic offer;
		logic [4:0] mask_ext;
		logic [7:0][3:0] ext_prio;
		logic [23:0][3:0] per_prio;
		setup = psel & ~penable;
		access = psel & penable & s.pready;
		idx = paddr[9:2];
		hit_prio = 1'b0;
		hit_ctrl = 1'b0;
		hit_flags = 1'b0;
		prio_sel = 3'h0;
		rd = 16'h0000;
		wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
		flags = 8'h00;
		nmi_edge = 1'b0;
		brk_edge = 1'b0;
		ack = 1'b0;
		act = '0;
		lvl = '0;
		elig = '0;
		found = 1'b0;
		best_lvl = 5'h00;
		best_src = 6'h00;
		best_vec = 8'h00;
		ext_clr = 1'b0;
		ext_fall = 8'h00;
		ext_set = 8'h00;
		nmi_clr = 1'b0;
		brk_clr = 1'b0;
		hit_any = 1'b0;
		wr_en = 1'b0;
		flag_wr = 1'b0;
		offer = 1'b0;
		mask_ext = {1'b0, cpu_mask_level};
		ext_prio = '0;
		per_prio = '0;
		next_s = s;

		// Address decode on the low index byte; an unmapped index answers with an error
		unique case (idx)
			idx_prio_a: begin
				hit_prio = 1'b1;
				prio_sel = 3'h0;
			end
			idx_prio_b: begin
				hit_prio = 1'b1;
				prio_sel = 3'h1;
			end
			idx_prio_c: begin
				hit_prio = 1'b1;
				prio_sel = 3'h2;
			end
			idx_prio_d: begin
				hit_prio = 1'b1;
				prio_sel = 3'h3;
			end
			idx_prio_e: begin
				hit_prio = 1'b1;
				prio_sel = 3'h4;
			end
			idx_prio_f: begin
				hit_prio = 1'b1;
				prio_sel = 3'h5;
			end
			idx_prio_g: begin
				hit_prio = 1'b1;
				prio_sel = 3'h6;
			end
			idx_prio_h: begin
				hit_prio = 1'b1;
				prio_sel = 3'h7;
			end
			idx_ctrl: begin
				hit_ctrl = 1'b1;
			end
			idx_flags: begin
				hit_flags = 1'b1;
			end
			default: begin
				hit_prio = 1'b0;
			end
		endcase
		hit_any = hit_prio | hit_ctrl | hit_flags;

		// Writes take effect only at the edge that completes the access
		wr_en = access & pwrite;
		flag_wr = wr_en & hit_flags & pstrb[0];

		// Synchronisers: only the second stage feeds logic
		next_s.nmi_sync = {s.nmi_sync[0], nmi_pin};
		next_s.nmi_prev = s.nmi_sync[1];
		next_s.ext_meta = ext_request_pins_n;
		next_s.ext_sync = s.ext_meta;
		next_s.ext_prev = s.ext_sync;
		next_s.brk_prev = break_req;

		if (s.edge_polarity_select) begin
			nmi_edge = s.nmi_sync[1] & ~s.nmi_prev; // R3
		end else begin
			nmi_edge = ~s.nmi_sync[1] & s.nmi_prev; // R3
		end
		brk_edge = break_req & ~s.brk_prev; // R7

		ack = cpu_ack & s.req.valid;

		// Pending latches; a new edge wins over a clear in the same cycle
		// Only the accepted source loses its latch
		nmi_clr = ack && s.src == `PIC_SRC_NMI;
		brk_clr = ack && s.src == `PIC_SRC_BRK;
		next_s.nmi_pend = nmi_edge | (s.nmi_pend & ~nmi_clr);
		next_s.brk_pend = brk_edge | (s.brk_pend & ~brk_clr); // R7

		for (int i = 0; i < `PIC_NUM_EXT; i++) begin
			// Zero bits clear, one bits are ignored, so a stray write cannot fake a request
			ext_clr = (ack && s.src == 6'(`PIC_SRC_EXT + i)) ||
				(flag_wr && !pwdata[i]); // R12 R13 R14
			ext_fall[i] = s.ext_prev[i] & ~s.ext_sync[i];
			ext_set[i] = s.sense_select_bits[i] & ext_fall[i];
			next_s.ext_latch[i] = ext_set[i] | (s.ext_latch[i] & ~ext_clr); // R12
			if (s.sense_select_bits[i]) begin
				flags[i] = s.ext_latch[i]; // R12
			end else begin
				flags[i] = ~s.ext_sync[i]; // R11
			end
		end

		// Register writes at the completing access edge
		if (wr_en) begin
			if (hit_prio) begin
				next_s.prio[prio_sel] = (s.prio[prio_sel] & ~wmask) | (pwdata[15:0] & wmask); // R10 R17
			end
			if (hit_ctrl) begin
				if (pstrb[1]) begin
					next_s.edge_polarity_select = pwdata[`PIC_CTRL_POL_BIT]; // R3
				end
				if (pstrb[0]) begin
					next_s.sense_select_bits = pwdata[7:0]; // R9
				end
			end
		end

		// Read data is captured in the setup cycle and held through the access
		if (hit_prio) begin
			rd = s.prio[prio_sel];
		end else if (hit_ctrl) begin
			rd[`PIC_CTRL_NMI_LVL_BIT] = s.nmi_sync[1]; // R5 R6
			rd[`PIC_CTRL_POL_BIT] = s.edge_polarity_select;
			rd[7:0] = s.sense_select_bits;
		end else if (hit_flags) begin
			rd[7:0] = flags;
		end
		// Zero wait states: the answer always stands in the first access cycle
		next_s.pready = setup;
		next_s.pslverr = setup & ~hit_any;
		if (setup) begin
			next_s.prdata = {16'h0000, rd};
		end

		// Source table, index order is the default ranking
		act[`PIC_SRC_NMI] = s.nmi_pend;
		lvl[`PIC_SRC_NMI] = `PIC_LVL_NMI; // R2
		act[`PIC_SRC_BRK] = s.brk_pend;
		lvl[`PIC_SRC_BRK] = `PIC_LVL_BRK; // R7
		for (int i = 0; i < `PIC_NUM_EXT; i++) begin
			// Fields run from the top nibble down, four sources to a register
			ext_prio[i] = s.prio[i / 4][(15 - 4 * (i % 4)) -: 4]; // R10
			act[`PIC_SRC_EXT + i] = flags[i]; // R11 R12
			lvl[`PIC_SRC_EXT + i] = {1'b0, ext_prio[i]}; // R10
		end
		for (int j = 0; j < `PIC_NUM_PER; j++) begin
			per_prio[j] = s.prio[2 + j / 4][(15 - 4 * (j % 4)) -: 4]; // R17
			act[`PIC_SRC_PER + j] = periph_req[j];
			lvl[`PIC_SRC_PER + j] = {1'b0, per_prio[j]}; // R17
		end

		// Level 0 can never exceed a mask, so it is masked for free
		for (int k = 0; k < `PIC_NUM_SRC; k++) begin
			// The mask is compared live; the offer it gates is registered one edge later
			elig[k] = act[k] && (k == 0 || lvl[k] > mask_ext); // R1 R2 R22
		end

		// Descending scan with >= lets the lower index win a tie
		for (int k = `PIC_NUM_SRC - 1; k >= 0; k--) begin
			if (elig[k] && lvl[k] >= best_lvl) begin // R21
				found = 1'b1;
				best_lvl = lvl[k];
				best_src = 6'(k);
			end
		end

		if (best_src == `PIC_SRC_NMI) begin
			best_vec = `PIC_VEC_NMI;
		end else if (best_src == `PIC_SRC_BRK) begin
			best_vec = `PIC_VEC_BRK;
		end else if (best_src < `PIC_SRC_PER) begin
			best_vec = `PIC_VEC_EXT + 8'(best_src - `PIC_SRC_EXT);
		end else begin
			best_vec = `PIC_VEC_PER + `PIC_VEC_PER_STEP * 8'(best_src - `PIC_SRC_PER); // R16
		end

		// One quiet cycle after an accept so a stale winner is not offered twice
		offer = found & ~ack;
		next_s.req.valid = offer;
		next_s.req.vector = best_vec;
		if (best_lvl >= `PIC_LVL_BRK) begin
			next_s.req.mask_level = `PIC_MASK_FIXED; // R4 R8
		end else begin
			next_s.req.mask_level = best_lvl[3:0]; // R15 R18
		end
		next_s.src = best_src;
		// Notify comes from the same term as the offer, so the two never disagree
		next_s.request_notify_out_n = ~offer; // R19
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s.nmi_sync <= 2'h0;
			s.nmi_prev <= 1'b0;
			s.nmi_pend <= 1'b0;
			s.brk_prev <= 1'b0;
			s.brk_pend <= 1'b0;
			// Pin stages start at the idle high level so release cannot fake an edge
			s.ext_meta <= `PIC_EXT_IDLE;
			s.ext_sync <= `PIC_EXT_IDLE;
			s.ext_prev <= `PIC_EXT_IDLE;
			s.ext_latch <= `PIC_FLAGS_RESET;
			s.prio <= {8{`PIC_PRIO_RESET}}; // R20
			s.edge_polarity_select <= 1'b0;
			s.sense_select_bits <= `PIC_SENSE_RESET;
			s.pready <= 1'b0;
			s.pslverr <= 1'b0;
			s.prdata <= 32'h00000000;
			s.req.valid <= 1'b0;
			s.req.vector <= 8'h00;
			s.req.mask_level <= 4'h0;
			s.src <= 6'h00;
			s.request_notify_out_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign cpu_req = s.req;
	assign request_notify_out_n = s.request_notify_out_n;

endmodule : pic_priority_controller

// file: pic_priority_controller_monitor.sv
`timescale 1ns/1ps
`include "pic_defs.svh"
module pic_priority_controller_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] cpu_mask_level,
	input wire logic cpu_ack,
	input pic_pkg::pic_cpu_req_s cpu_req,
	input wire logic request_notify_out_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_notify; request_notify_out_n == !cpu_req.valid; endproperty
	a_notify: assert property (p_notify) else $error("notify pin wrong");
	// The offer is registered, so it answers the mask seen one edge earlier
	property p_above; cpu_req.valid && cpu_req.vector != `PIC_VEC_NMI
		|-> cpu_req.mask_level > $past(cpu_mask_level); endproperty
	a_above: assert property (p_above) else $error("offer not above mask");
	property p_fixed; cpu_req.valid && cpu_req.vector inside {`PIC_VEC_NMI, `PIC_VEC_BRK}
		|-> cpu_req.mask_level == `PIC_MASK_FIXED; endproperty
	a_fixed: assert property (p_fixed) else $error("fixed level wrong");
	property p_vector; cpu_req.valid |-> cpu_req.vector inside {8'h0B, 8'h0C, [8'h40:8'h47]}
		|| (cpu_req.vector inside {[8'h48:8'hA4]} && cpu_req.vector[1:0] == 2'b00); endproperty
	a_vector: assert property (p_vector) else $error("illegal vector");
	property p_setup; psel && !penable |=> pready; endproperty
	a_setup: assert property (p_setup) else $error("no answer to setup");
	property p_single; pready |=> !pready; endproperty
	a_single: assert property (p_single) else $error("ready held too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_ack; cpu_ack && cpu_req.valid |=> !cpu_req.valid; endproperty
	a_ack: assert property (p_ack) else $error("offer kept after ack");
endmodule : pic_priority_controller_monitor
bind pic_priority_controller pic_priority_controller_monitor u_mon (.*);

// file: pic_cpu_model.sv
`timescale 1ns/1ps
module pic_cpu_model (
	input wire logic pclk,
	input wire logic presetn,
	input pic_pkg::pic_cpu_req_s cpu_req,
	input wire logic ack_en,
	input wire logic slow,
	input wire logic restore,
	input wire logic [3:0] restore_lvl,
	output logic cpu_ack,
	output logic [3:0] cpu_mask_level,
	output logic [7:0] last_vec
);
	logic [1:0] wait_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_ack <= 1'b0;
			cpu_mask_level <= 4'h0;
			last_vec <= 8'h00;
			wait_cnt <= 2'h0;
		end else begin
			// One pulse per offer; slow mode waits three cycles first
			cpu_ack <= ack_en && cpu_req.valid && !cpu_ack && wait_cnt >= {slow, slow};
			wait_cnt <= (cpu_req.valid && !cpu_ack) ? wait_cnt + 2'h1 : 2'h0;
			if (cpu_ack && cpu_req.valid) begin
				cpu_mask_level <= cpu_req.mask_level;
				last_vec <= cpu_req.vector;
			end else if (restore) begin
				cpu_mask_level <= restore_lvl;
			end
		end
	end
endmodule : pic_cpu_model

// file: tb_priority_interrupt_controller.sv
`timescale 1ns/1ps
`include "pic_defs.svh"
module tb_priority_interrupt_controller;
	localparam logic [7:0] ia = 8'(`PIC_IDX_PRIO_A);
	localparam logic [7:0] ictl = 8'(`PIC_IDX_CTRL);
	localparam logic [7:0] iflg = 8'(`PIC_IDX_FLAGS);
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic nmi_pin, break_req, cpu_ack, ack_en, slow, restore, notify_n;
	logic [31:0] paddr, pwdata, prdata;
	logic [15:0] r;
	logic [7:0] ext_n, last_vec;
	logic [23:0] periph_req;
	logic [3:0] mask, restore_lvl;
	pic_pkg::pic_cpu_req_s cpu_req;
	int err_count, samples_checked;
	pic_priority_controller DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin), .ext_request_pins_n(ext_n),
		.break_req(break_req), .periph_req(periph_req), .cpu_mask_level(mask), .cpu_ack(cpu_ack),
		.cpu_req(cpu_req), .request_notify_out_n(notify_n));
	pic_cpu_model cpu (.pclk(pclk), .presetn(presetn), .cpu_req(cpu_req), .ack_en(ack_en),
		.slow(slow), .restore(restore), .restore_lvl(restore_lvl), .cpu_ack(cpu_ack),
		.cpu_mask_level(mask), .last_vec(last_vec));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic test_done;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	task automatic ck(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask : ck
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
		output logic [15:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {22'h0, idx, 2'b00};
		pwdata <= {16'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			test_done();
		end
		rd = prdata[15:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		apb(1'b1, idx, d, r, e);
	endtask : wr
	task automatic rd(input string what, input logic [7:0] idx, input logic [15:0] exp);
		apb(1'b0, idx, 16'h0000, r, e);
		ck(what, exp, r);
	endtask : rd
	task automatic wack(input logic [7:0] vec, input logic [3:0] lvl);
		int n;
		n = 0;
		do @(posedge pclk); while (cpu_ack !== 1'b1 && ++n < 50);
		if (cpu_ack !== 1'b1) begin
			err_count++;
			test_done();
		end
		@(posedge pclk);
		ck("vector", {8'h00, vec}, {8'h00, last_vec});
		ck("mask", {12'h000, lvl}, {12'h000, mask});
	endtask : wack
	initial begin
		err_count = 0;
		samples_checked = 0;
		{psel, penable, pwrite, break_req, ack_en, slow, restore} = 7'h00;
		paddr = 32'h0;
		pwdata = 32'h0;
		nmi_pin = 1'b1;
		ext_n = `PIC_EXT_IDLE;
		periph_req = 24'h0;
		restore_lvl = 4'h0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		for (int i = 0; i < 8; i++) rd("prio", ia + 8'(2 * i), `PIC_PRIO_RESET);
		rd("ctrl", ictl, 16'h8000);
		rd("flags", iflg, 16'h0000);
		apb(1'b0, 8'h00, 16'h0000, r, e);
		ck("slverr", 16'h0001, {15'h0, e});
		for (int i = 0; i < 8; i++) wr(ia + 8'(2 * i), 16'h5A00 + 16'(i));
		for (int i = 0; i < 8; i++) rd("prio rw", ia + 8'(2 * i), 16'h5A00 + 16'(i));
		$display("register test done");
		wr(ia, 16'h5700);
		wr(ia + 8'h04, 16'h3030);
		wr(ictl, 16'h0001);
		ext_n <= 8'hFE;
		repeat (6) @(posedge pclk);
		rd("edge flag", iflg, 16'h0001);
		wr(iflg, 16'h00FF);
		ext_n <= 8'hFF;
		repeat (6) @(posedge pclk);
		rd("flag held", iflg, 16'h0001);
		wr(iflg, 16'h00FE);
		rd("flag cleared", iflg, 16'h0000);
		ext_n <= 8'hFE;
		ack_en <= 1'b1;
		wack(`PIC_VEC_EXT, 4'h5);
		rd("flag taken", iflg, 16'h0000);
		ack_en <= 1'b0;
		ext_n <= 8'hFC;
		repeat (6) @(posedge pclk);
		rd("level flag", iflg, 16'h0002);
		ck("level offer", 16'h0001, {15'h0, cpu_req.valid});
		ck("notify low", 16'h0000, {15'h0, notify_n});
		ext_n <= 8'hFE;
		repeat (6) @(posedge pclk);
		rd("level gone", iflg, 16'h0000);
		$display("pin test done");
		periph_req <= 24'h000007;
		repeat (6) @(posedge pclk);
		ck("below mask", 16'h0000, {15'h0, cpu_req.valid});
		ck("notify high", 16'h0001, {15'h0, notify_n});
		restore_lvl <= 4'h2;
		restore <= 1'b1;
		@(posedge pclk);
		restore <= 1'b0;
		ack_en <= 1'b1;
		wack(`PIC_VEC_PER, 4'h3);
		periph_req <= 24'h0;
		$display("peripheral test done");
		ack_en <= 1'b0;
		break_req <= 1'b1;
		@(posedge pclk);
		break_req <= 1'b0;
		repeat (6) @(posedge pclk);
		ck("break held", 16'h0001, {15'h0, cpu_req.valid});
		slow <= 1'b1;
		ack_en <= 1'b1;
		wack(`PIC_VEC_BRK, `PIC_MASK_FIXED);
		$display("break test done");
		nmi_pin <= 1'b0;
		wack(`PIC_VEC_NMI, `PIC_MASK_FIXED);
		rd("nmi low", ictl, 16'h0001);
		wr(ictl, 16'h0101);
		nmi_pin <= 1'b1;
		wack(`PIC_VEC_NMI, `PIC_MASK_FIXED);
		rd("nmi high", ictl, 16'h8101);
		$display("nmi test done");
		nmi_pin <= 1'b0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd("ctrl low", ictl, 16'h0000);
		rd("prio cleared", ia + 8'h02, `PIC_PRIO_RESET);
		ck("level zero", 16'h0000, {15'h0, cpu_req.valid});
		ck("notify idle", 16'h0001, {15'h0, notify_n});
		$display("reset test done");
		test_done();
	end
endmodule : tb_priority_interrupt_controller
